// file: dv/ivp_core_model.sv
// Behavioural processor core that stands on the far side of the vector unit.
// Assumes the core outputs are registers on ref_clk; on a probe it looks at them after a chosen delay.
module ivp_core_model
    import ivp_pkg::*;
(
    // Clock and control.
    input  wire logic        ref_clk,
    input  wire logic        probe,
    input  wire logic [1:0]  hold,
    // Vector unit outputs.
    input  wire logic        core_req,
    input  wire ivp_vec_t    core_vector,
    input  wire ivp_lvl_t    core_level,
    input  wire logic [31:0] core_offset,
    // Observation.
    output logic             seen,
    output logic [45:0]      seen_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_q;
    initial begin
        seen = 1'b0;
        seen_data = '0;
        wait_q = 3'h0;
    end
    // A slow core looks late, so the request must have stood unchanged all along.
    always @(posedge ref_clk) begin
        seen <= 1'b0;
        if (probe) begin
            wait_q <= {1'b0, hold} + 3'h1;
        end else if (wait_q == 3'h1) begin
            seen      <= 1'b1;
            seen_data <= {core_req, core_level, core_vector, core_offset};
            wait_q    <= 3'h0;
        end else if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
        end
    end
endmodule : ivp_core_model

// file: dv/tb.sv
// Self-checking bench of the interrupt vector unit: APB master, source driver and core model.
// Assumes the unit answers APB in two access cycles and updates its core outputs one edge after its inputs.
`include "ivp_regs.svh"
module tb
    import ivp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0, arst_n = 1'b0, ce = 1'b1, probe = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, core_req, irq, seen;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, core_offset;
    logic [13:0] src = 14'h0000;
    logic [1:0]  hold = 2'h0;
    logic [15:0] rnd = 16'h0021;
    logic [15:0] sh [4] = '{default: 16'h0000};
    logic [15:0] wm [4] = '{`IVP_EXT_A_WMASK, `IVP_EXT_B_WMASK, `IVP_CONV_A_WMASK, `IVP_CONV_B_WMASK};
    logic [7:0]  vt [14] = '{8'h0B, 8'h0C, 8'h0E, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46,
                             8'h5B, 8'h5C, 8'h60, 8'h64};
    logic [46:0] expq [$];
    logic [45:0] seen_data;
    ivp_vec_t    core_vector;
    ivp_lvl_t    core_level;
    int          n_errors = 0, tests_run = 0, cyc = 0, i, p;

    ivp_top i_ivp_top (.ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .nmi_req(src[0]),
        .break_controller(src[1]), .debug_req(src[2]), .external_request(src[9:3]),
        .flash_ready_interrupt(src[10]), .conversion_end(src[13:11]), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .core_req(core_req), .core_vector(core_vector), .core_level(core_level),
        .core_offset(core_offset), .irq(irq));
    ivp_core_model i_ivp_core_model (.ref_clk(ref_clk), .probe(probe), .hold(hold), .core_req(core_req),
        .core_vector(core_vector), .core_level(core_level), .core_offset(core_offset), .seen(seen),
        .seen_data(seen_data));

    always #5 ref_clk = ~ref_clk;

    task automatic cmp(input logic [45:0] got, input logic [45:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // Entries without the full flag only check that no request stands.
    task automatic take(input logic [45:0] got);
        logic [46:0] e;
        // An answer that nobody expected is forced to mismatch.
        e = (expq.size() > 0) ? expq.pop_front() : {1'b1, ~got};
        if (e[46]) cmp(got, e[45:0]);
        else cmp({got[45], 45'h0}, {e[45], 45'h0});
    endtask : take

    always @(posedge ref_clk) begin
        if (seen === 1'b1) take(seen_data);
        if (psel && penable && pready === 1'b1 && !pwrite) take({13'h0, pslverr, prdata});
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        // Only the bench's cycle ceiling ends a wait that never sees ready.
        while (pready !== 1'b1) @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic err);
        expq.push_back({1'b1, 13'h0, err, v});
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic wr_prio(input int idx, input logic [15:0] d);
        sh[idx] = d & wm[idx];
        apb(1'b1, 8'(4 * idx), {16'hFFFF, d});
    endtask : wr_prio

    function automatic logic [4:0] lvl_of(input int s);
        case (s)
            0: return `IVP_LVL_NMI;
            1, 2, 10: return `IVP_LVL_FIXED;
            3, 4, 5, 6: return {1'b0, sh[0][15 - 4 * (s - 3) -: 4]};
            7, 8, 9: return {1'b0, sh[1][15 - 4 * (s - 7) -: 4]};
            11, 12: return {1'b0, sh[2][7 - 4 * (s - 11) -: 4]};
            default: return {1'b0, sh[3][7:4]};
        endcase
    endfunction : lvl_of

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    // Strictly greater keeps the earlier source on a tie.
    task automatic check_core(input logic [13:0] s);
        int j, b;
        logic [4:0] best;
        best = 5'h00;
        b = 0;
        for (j = 0; j < 14; j++) if (s[j] && lvl_of(j) > best) begin
            best = lvl_of(j);
            b = j;
        end
        @(posedge ref_clk);
        src <= s;
        repeat (2) @(posedge ref_clk);
        if (best == 5'h00) expq.push_back({2'b00, 45'h0});
        else expq.push_back({2'b11, best, vt[b], 22'h0, vt[b], 2'b00});
        rnd = lfsr_next(rnd);
        probe <= 1'b1;
        hold <= rnd[1:0];
        @(posedge ref_clk);
        probe <= 1'b0;
        while (seen !== 1'b1) @(posedge ref_clk);
    endtask : check_core

    task automatic wrap_up;
        // An expected answer that never came counts as a mismatch.
        n_errors += expq.size();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        for (i = 0; i < 7; i++) rd(8'(4 * i), 32'h0000_0000, 1'b0);
        rd(8'h1C, 32'h0000_0000, 1'b1);
        for (i = 0; i < 4; i++) wr_prio(i, 16'hFFFF);
        for (i = 0; i < 4; i++) rd(8'(4 * i), {16'h0, sh[i]}, 1'b0);
        $display("test 1 done");
        for (p = 0; p < 2; p++) begin
            for (i = 0; i < 4; i++) wr_prio(i, (p == 0) ? rnd ^ 16'(i * 16'h3A5C) : 16'h0000);
            for (i = 0; i < 14; i++) check_core(14'(1 << i));
        end
        $display("test 2 done");
        for (i = 0; i < 4; i++) wr_prio(i, 16'hFFFF);
        for (i = 0; i < 4; i++) check_core(14'h3FFF << i);
        check_core(14'h0018);
        check_core(14'h0008);
        wr_prio(0, 16'h1000);
        check_core(14'h2008);
        $display("test 3 done");
        for (p = 0; p < 10; p++) begin
            for (i = 0; i < 4; i++) wr_prio(i, rnd ^ 16'(p * 16'h1D3));
            check_core(rnd[13:0] ^ 14'(p * 14'h2E9));
        end
        $display("test 4 done");
        check_core(14'h0000);
        apb(1'b1, `IVP_OFF_STATUS, 32'h0000_3FFF);
        apb(1'b1, `IVP_OFF_MASK, 32'h0000_0000);
        rd(`IVP_OFF_STATUS, 32'h0000_0000, 1'b0);
        check_core(14'h2000);
        check_core(14'h0000);
        cmp({45'h0, irq}, 46'h0);
        apb(1'b1, `IVP_OFF_MASK, 32'h0000_2000);
        repeat (2) @(posedge ref_clk);
        cmp({45'h0, irq}, 46'h1);
        rd(`IVP_OFF_STATUS, 32'h0000_2000, 1'b0);
        apb(1'b1, `IVP_OFF_STATUS, 32'h0000_2000);
        repeat (2) @(posedge ref_clk);
        cmp({45'h0, irq}, 46'h0);
        rd(`IVP_OFF_STATUS, 32'h0000_0000, 1'b0);
        $display("test 5 done");
        @(posedge ref_clk);
        ce <= 1'b0;
        src <= 14'h0001;
        repeat (3) @(posedge ref_clk);
        cmp({45'h0, core_req}, 46'h0);
        ce <= 1'b1;
        check_core(14'h0001);
        $display("test 6 done");
        repeat (4) @(posedge ref_clk);
        wrap_up();
    end
endmodule : tb

// file: hw/ivp_pkg.sv
// Types shared by the interrupt vector block.
// Assumes nothing beyond a SystemVerilog compiler.
package ivp_pkg;
    localparam int IVP_NSRC = 14;
    typedef logic [4:0]  ivp_lvl_t;
    typedef logic [7:0]  ivp_vec_t;
    typedef logic [15:0] ivp_prio_reg_t;
    typedef enum logic [0:0] {IVP_IDLE, IVP_ANSWER} ivp_bus_state_t;
endpackage : ivp_pkg

// file: hw/ivp_regs.svh
// Register offsets, field positions, reset values and vector constants of the interrupt vector block.
// Assumes a 32-bit APB register bus with one aligned word per register.
`ifndef IVP_REGS_SVH
`define IVP_REGS_SVH

`define IVP_OFF_EXT_A        8'h00
`define IVP_OFF_EXT_B        8'h04
`define IVP_OFF_CONV_A       8'h08
`define IVP_OFF_CONV_B       8'h0C
`define IVP_OFF_STATUS       8'h10
`define IVP_OFF_MASK         8'h14
`define IVP_OFF_CURRENT      8'h18

`define IVP_PRIO_RESET       16'h0000
`define IVP_MASK_RESET       14'h0000
`define IVP_EXT_A_WMASK      16'hFFFF
`define IVP_EXT_B_WMASK      16'hFFF0
`define IVP_CONV_A_WMASK     16'h00FF
`define IVP_CONV_B_WMASK     16'h00F0

`define IVP_FLD_HI           12
`define IVP_FLD_MH           8
`define IVP_FLD_ML           4
`define IVP_FLD_LO           0

`define IVP_LVL_NMI          5'h10
`define IVP_LVL_FIXED        5'h0F

`define IVP_VEC_NMI          8'h0B
`define IVP_VEC_BREAK        8'h0C
`define IVP_VEC_DEBUG        8'h0E
`define IVP_VEC_EXT0         8'h40
`define IVP_VEC_FLASH        8'h5B
`define IVP_VEC_CONV0        8'h5C
`define IVP_VEC_CONV1        8'h60
`define IVP_VEC_CONV2        8'h64

`endif

// file: hw/ivp_src_cell.sv
// One interrupt source: turns its request and priority field into an eligible flag and a level.
// Assumes the request is synchronous to the block clock; purely combinational.
module ivp_src_cell
    import ivp_pkg::*;
#(
    parameter logic     FIXED     = 1'b0,
    parameter ivp_lvl_t FIXED_LVL = 5'h00
) (
    // Source side.
    input  wire logic       req,
    input  wire logic [3:0] field,
    // Arbiter side.
    output logic            elig,
    output ivp_lvl_t        lvl
);
    // A programmable source at level zero is held off entirely.
    always_comb begin
        lvl  = FIXED ? FIXED_LVL : {1'b0, field};
        elig = req && (lvl != 5'h00);
    end
endmodule : ivp_src_cell

// file: hw/ivp_top.sv
// Interrupt vector and priority unit: picks the pending source of highest level and hands its vector,
// level and table offset to the processor core.
// Assumes source requests are levels synchronous to ref_clk and an APB master on the register bus.
//
// Our own choices: the address map and register access over APB.
`include "ivp_regs.svh"

module ivp_top
    import ivp_pkg::*;
(
    // Clock, reset and clock enable.
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    // Interrupt sources.
    input  wire logic        nmi_req,
    input  wire logic        break_controller,
    input  wire logic        debug_req,
    input  wire logic [6:0]  external_request,
    input  wire logic        flash_ready_interrupt,
    input  wire logic [2:0]  conversion_end,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Processor core.
    output logic             core_req,
    output ivp_vec_t         core_vector,
    output ivp_lvl_t         core_level,
    output logic [31:0]      core_offset,
    // Event interrupt.
    output logic             irq
);
    ivp_prio_reg_t          external_priority_a_q;
    ivp_prio_reg_t          external_priority_b_q;
    ivp_prio_reg_t          converter_priority_a_q;
    ivp_prio_reg_t          converter_priority_b_q;
    logic [IVP_NSRC-1:0]    mask_q;
    logic [IVP_NSRC-1:0]    status_q;
    ivp_bus_state_t         bus_state_q;
    logic                   pready_q;
    logic [31:0]            prdata_q;
    logic                   pslverr_q;
    logic                   core_req_q;
    ivp_vec_t               core_vector_q;
    ivp_lvl_t               core_level_q;
    logic [31:0]            core_offset_q;
    logic                   irq_q;

    // A parameter override needs an elaboration constant, so the fixed set lives in a localparam.
    localparam logic [IVP_NSRC-1:0] FIXED_SRC = 14'h0407;

    logic [IVP_NSRC-1:0]    src;
    logic [IVP_NSRC-1:0]    fixed_src;
    logic [3:0]             field   [IVP_NSRC];
    ivp_vec_t               vec_tab [IVP_NSRC];
    logic [IVP_NSRC-1:0]    elig;
    ivp_lvl_t               lvl     [IVP_NSRC];
    logic                   best_any;
    ivp_lvl_t               best_lvl;
    ivp_vec_t               best_vec;
    logic                   access;
    logic                   commit_wr;
    logic                   addr_ok;
    logic [31:0]            rd_mux;
    logic                   status_clr;

    // Source order is the default order, index 0 ranking highest.
    assign src = {conversion_end, flash_ready_interrupt, external_request, debug_req, break_controller, nmi_req};
    assign fixed_src = FIXED_SRC;

    // Field selection per source.
    always_comb begin
        field[0]  = 4'h0;
        field[1]  = 4'h0;
        field[2]  = 4'h0;
        field[3]  = external_priority_a_q[`IVP_FLD_HI +: 4];
        field[4]  = external_priority_a_q[`IVP_FLD_MH +: 4];
        field[5]  = external_priority_a_q[`IVP_FLD_ML +: 4];
        field[6]  = external_priority_a_q[`IVP_FLD_LO +: 4];
        field[7]  = external_priority_b_q[`IVP_FLD_HI +: 4];
        field[8]  = external_priority_b_q[`IVP_FLD_MH +: 4];
        field[9]  = external_priority_b_q[`IVP_FLD_ML +: 4];
        field[10] = 4'h0;
        field[11] = converter_priority_a_q[`IVP_FLD_ML +: 4];
        field[12] = converter_priority_a_q[`IVP_FLD_LO +: 4];
        field[13] = converter_priority_b_q[`IVP_FLD_ML +: 4];
    end

    // Vector numbers per source.
    always_comb begin
        vec_tab[0]  = `IVP_VEC_NMI;
        vec_tab[1]  = `IVP_VEC_BREAK;
        vec_tab[2]  = `IVP_VEC_DEBUG;
        for (int i = 0; i < 7; i++) begin
            vec_tab[3+i] = `IVP_VEC_EXT0 + ivp_vec_t'(i);
        end
        vec_tab[10] = `IVP_VEC_FLASH;
        vec_tab[11] = `IVP_VEC_CONV0;
        vec_tab[12] = `IVP_VEC_CONV1;
        vec_tab[13] = `IVP_VEC_CONV2;
    end

    // Fixed levels: NMI above any programmable value, the other fixed sources at 15.
    genvar g;
    generate
        for (g = 0; g < IVP_NSRC; g++) begin : g_src
            ivp_src_cell #(
                .FIXED     (FIXED_SRC[g]),
                .FIXED_LVL ((g == 0) ? `IVP_LVL_NMI : `IVP_LVL_FIXED)
            ) u_cell (
                .req   (src[g]),
                .field (field[g]),
                .elig  (elig[g]),
                .lvl   (lvl[g])
            );
        end
    endgenerate

    // Scanning from the lowest rank upward with >= lets the higher-ranked source take a tie.
    always_comb begin
        best_any = 1'b0;
        best_lvl = 5'h00;
        best_vec = 8'h00;
        for (int i = IVP_NSRC - 1; i >= 0; i--) begin
            if (elig[i] && (!best_any || lvl[i] >= best_lvl)) begin
                best_any = 1'b1;
                best_lvl = lvl[i];
                best_vec = vec_tab[i];
            end
        end
    end

    // Core request outputs, refreshed every enabled cycle.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            core_req_q    <= 1'b0;
            core_vector_q <= 8'h00;
            core_level_q  <= 5'h00;
            core_offset_q <= 32'h0000_0000;
        end else if (ce) begin
            core_req_q    <= best_any;
            core_vector_q <= best_vec;
            core_level_q  <= best_lvl;
            core_offset_q <= {22'h00_0000, best_vec, 2'b00};
        end
    end

    // APB: access phase is answered on its second cycle; writes commit at the completing edge.
    assign access    = psel && penable;
    assign commit_wr = access && pready_q && pwrite && !pslverr_q;
    assign addr_ok   = (paddr == `IVP_OFF_EXT_A) || (paddr == `IVP_OFF_EXT_B) || (paddr == `IVP_OFF_CONV_A)
                    || (paddr == `IVP_OFF_CONV_B) || (paddr == `IVP_OFF_STATUS) || (paddr == `IVP_OFF_MASK)
                    || (paddr == `IVP_OFF_CURRENT);

    always_comb begin
        case (paddr)
            `IVP_OFF_EXT_A:   rd_mux = {16'h0000, external_priority_a_q};
            `IVP_OFF_EXT_B:   rd_mux = {16'h0000, external_priority_b_q};
            `IVP_OFF_CONV_A:  rd_mux = {16'h0000, converter_priority_a_q};
            `IVP_OFF_CONV_B:  rd_mux = {16'h0000, converter_priority_b_q};
            `IVP_OFF_STATUS:  rd_mux = {18'h0_0000, status_q};
            `IVP_OFF_MASK:    rd_mux = {18'h0_0000, mask_q};
            `IVP_OFF_CURRENT: rd_mux = {core_req_q, 10'h000, core_level_q, 8'h00, core_vector_q};
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_state_q <= IVP_IDLE;
            pready_q    <= 1'b0;
            prdata_q    <= 32'h0000_0000;
            pslverr_q   <= 1'b0;
        end else if (ce) begin
            case (bus_state_q)
                IVP_IDLE: begin
                    if (access) begin
                        bus_state_q <= IVP_ANSWER;
                        pready_q    <= 1'b1;
                        prdata_q    <= pwrite ? 32'h0000_0000 : rd_mux;
                        pslverr_q   <= !addr_ok;
                    end
                end
                IVP_ANSWER: begin
                    bus_state_q <= IVP_IDLE;
                    pready_q    <= 1'b0;
                    prdata_q    <= 32'h0000_0000;
                    pslverr_q   <= 1'b0;
                end
                default: begin
                    bus_state_q <= IVP_IDLE;
                    pready_q    <= 1'b0;
                end
            endcase
        end
    end

    // Priority registers; reserved bits stay zero whatever is written.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            external_priority_a_q  <= `IVP_PRIO_RESET;
            external_priority_b_q  <= `IVP_PRIO_RESET;
            converter_priority_a_q <= `IVP_PRIO_RESET;
            converter_priority_b_q <= `IVP_PRIO_RESET;
        end else if (ce && commit_wr) begin
            case (paddr)
                `IVP_OFF_EXT_A:  external_priority_a_q  <= pwdata[15:0] & `IVP_EXT_A_WMASK;
                `IVP_OFF_EXT_B:  external_priority_b_q  <= pwdata[15:0] & `IVP_EXT_B_WMASK;
                `IVP_OFF_CONV_A: converter_priority_a_q <= pwdata[15:0] & `IVP_CONV_A_WMASK;
                `IVP_OFF_CONV_B: converter_priority_b_q <= pwdata[15:0] & `IVP_CONV_B_WMASK;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_q <= `IVP_MASK_RESET;
        end else if (ce && commit_wr && paddr == `IVP_OFF_MASK) begin
            mask_q <= pwdata[IVP_NSRC-1:0];
        end
    end

    // Each pending request also latches a sticky event flag for polling software.
    assign status_clr = commit_wr && (paddr == `IVP_OFF_STATUS);

    ivp_w1c_flags #(
        .W (IVP_NSRC)
    ) u_status (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .ce       (ce),
        .set      (src),
        .clr_we   (status_clr),
        .clr_data (pwdata[IVP_NSRC-1:0]),
        .flags_q  (status_q)
    );

    // Uses the flags' next value so the level follows a clear in the same cycle.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= |(((status_q & ~(status_clr ? pwdata[IVP_NSRC-1:0] : '0)) | src) & mask_q);
        end
    end

    assign pready      = pready_q;
    assign prdata      = prdata_q;
    assign pslverr     = pslverr_q;
    assign core_req    = core_req_q;
    assign core_vector = core_vector_q;
    assign core_level  = core_level_q;
    assign core_offset = core_offset_q;
    assign irq         = irq_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    a_nmi_wins: assert property (
        ce && nmi_req |=> core_req && core_vector == 8'h0B && core_level == 5'h10 && core_offset == 32'h0000_002C)
        else $error("NMI not delivered on vector 11 at level 16");
    a_break_fixed: assert property (
        ce && break_controller && !nmi_req |=> core_vector == 8'h0C && core_level == 5'h0F)
        else $error("Break controller not on vector 12 level 15");
    a_debug_fixed: assert property (
        ce && src == 14'h0004 |=> core_vector == 8'h0E && core_level == 5'h0F && core_offset == 32'h0000_0038)
        else $error("Debug interrupt not on vector 14 level 15");
    a_ext0_field: assert property (
        ce && src == 14'h0008 && external_priority_a_q[15:12] != 4'h0 |=> core_vector == 8'h40
        && core_offset == 32'h0000_0100 && core_level == {1'b0, $past(external_priority_a_q[15:12])})
        else $error("Request 0 vector or level wrong");
    a_ext2_field: assert property (
        ce && src == 14'h0020 && external_priority_a_q[7:4] != 4'h0
        |=> core_vector == 8'h42 && core_level == {1'b0, $past(external_priority_a_q[7:4])})
        else $error("Request 2 vector or level wrong");
    a_ext3_field: assert property (
        ce && src == 14'h0040 && external_priority_a_q[3:0] != 4'h0
        |=> core_vector == 8'h43 && core_level == {1'b0, $past(external_priority_a_q[3:0])})
        else $error("Request 3 vector or level wrong");
    a_ext4_field: assert property (
        ce && src == 14'h0080 && external_priority_b_q[15:12] != 4'h0
        |=> core_vector == 8'h44 && core_level == {1'b0, $past(external_priority_b_q[15:12])})
        else $error("Request 4 vector or level wrong");
    a_ext5_field: assert property (
        ce && src == 14'h0100 && external_priority_b_q[11:8] != 4'h0
        |=> core_vector == 8'h45 && core_level == {1'b0, $past(external_priority_b_q[11:8])})
        else $error("Request 5 vector or level wrong");
    a_ext6_field: assert property (
        ce && src == 14'h0200 && external_priority_b_q[7:4] != 4'h0
        |=> core_vector == 8'h46 && core_level == {1'b0, $past(external_priority_b_q[7:4])})
        else $error("Request 6 vector or level wrong");
    a_flash_fixed: assert property (
        ce && src == 14'h0400 |=> core_vector == 8'h5B && core_level == 5'h0F && core_offset == 32'h0000_016C)
        else $error("Flash ready not on vector 91 level 15");
    a_conv0_field: assert property (
        ce && src == 14'h0800 && converter_priority_a_q[7:4] != 4'h0
        |=> core_vector == 8'h5C && core_level == {1'b0, $past(converter_priority_a_q[7:4])})
        else $error("Conversion end 0 vector or level wrong");
    a_conv1_field: assert property (
        ce && src == 14'h1000 && converter_priority_a_q[3:0] != 4'h0 |=> core_vector == 8'h60
        && core_offset == 32'h0000_0180 && core_level == {1'b0, $past(converter_priority_a_q[3:0])})
        else $error("Conversion end 1 vector or level wrong");
    a_conv2_field: assert property (
        ce && src == 14'h2000 && converter_priority_b_q[7:4] != 4'h0
        |=> core_vector == 8'h64 && core_level == {1'b0, $past(converter_priority_b_q[7:4])})
        else $error("Conversion end 2 vector or level wrong");
    a_tie_order: assert property (
        ce && src == 14'h0018 && external_priority_a_q[15:12] == external_priority_a_q[11:8]
        && external_priority_a_q[15:12] != 4'h0 |=> core_vector == 8'h40)
        else $error("Tie not resolved by default order");
    a_offset_times4: assert property (
        core_offset == {22'h00_0000, core_vector, 2'b00})
        else $error("Offset is not vector times four");
    a_zero_blocks: assert property (
        ce && (src & ~fixed_src) == src && external_priority_a_q == 16'h0000 && external_priority_b_q == 16'h0000
        && converter_priority_a_q == 16'h0000 && converter_priority_b_q == 16'h0000 |=> !core_req)
        else $error("Request raised for a level-zero source");
    a_irq_follows: assert property (
        ce && |(status_q & mask_q) && !status_clr |=> irq)
        else $error("Unmasked event flag did not raise the interrupt");
    a_ce_freeze: assert property (
        !ce |=> $stable(core_req) && $stable(core_vector) && $stable(core_level) && $stable(pready))
        else $error("Outputs moved while the clock enable was low");
    a_bus_pulse: assert property (
        ce && pready |=> !pready)
        else $error("Ready stood longer than one enabled cycle");

    c_nmi_taken: cover property (ce && nmi_req ##1 core_req);
    c_ext_preempt: cover property (core_req && core_vector == 8'h40 ##[1:20] core_req && core_vector == 8'h0C);
    c_apb_read: cover property (psel && penable && !pwrite && pready);
    c_irq_raised: cover property (!irq ##1 irq);
endmodule : ivp_top

// file: hw/ivp_w1c_flags.sv
// Sticky event flags, cleared by writing ones.
// Assumes set and clear are synchronous to the clock; set wins over clear.
module ivp_w1c_flags
    import ivp_pkg::*;
#(
    parameter int W = 14
) (
    // Clock and reset.
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    input  wire logic         ce,
    // Events and clear.
    input  wire logic [W-1:0] set,
    input  wire logic         clr_we,
    input  wire logic [W-1:0] clr_data,
    // Flags.
    output logic      [W-1:0] flags_q
);
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_q <= '0;
        end else if (ce) begin
            flags_q <= (flags_q & ~(clr_we ? clr_data : '0)) | set;
        end
    end
endmodule : ivp_w1c_flags
